/* src/cpf_pkg.sv */
// Constants and types for the physical-layer fault flag block.
// Assumes an 8-bit register port with one-cycle read latency.
package cpf_pkg;
  localparam int          CPF_AW          = 4;        // Register address width
  localparam logic [3:0]  CPF_ADDR_STATUS = 4'h5;     // Live status mirror
  localparam logic [3:0]  CPF_ADDR_ENABLE = 4'h6;     // Interrupt enables
  localparam logic [3:0]  CPF_ADDR_FLAGS  = 4'h7;     // Sticky fault flags
  localparam logic [7:0]  CPF_FLAGS_RST   = 8'h00;    // Flag reset value
  localparam logic [7:0]  CPF_ENABLE_RST  = 8'h00;    // Enable reset value
  localparam logic [7:0]  CPF_FLAGS_MASK  = 8'hFB;    // Bit 2 reads zero
  localparam logic [7:0]  CPF_ENABLE_MASK = 8'h19;    // Bits 4, 3, 0
  localparam int          CPF_BIT_HVH     = 7;        // High line over-volt
  localparam int          CPF_BIT_HVL     = 6;        // High line under-volt
  localparam int          CPF_BIT_LVH     = 5;        // Low line over-volt
  localparam int          CPF_BIT_LVL     = 4;        // Low line under-volt
  localparam int          CPF_BIT_DT      = 3;        // Dominant timeout
  localparam int          CPF_BIT_HOC     = 1;        // High line over-current
  localparam int          CPF_BIT_LOC     = 0;        // Low line over-current
  localparam int          CPF_EN_VF       = 4;        // Voltage-fail enable
  localparam int          CPF_EN_DT       = 3;        // Timeout enable
  localparam int          CPF_EN_OC       = 0;        // Over-current enable

  // Inputs from the fault detectors, all asynchronous to the clock
  typedef struct packed {
    logic hi_volt_high;   // High line voltage-high status
    logic hi_volt_low;    // High line voltage-low status
    logic lo_volt_high;   // Low line voltage-high status
    logic lo_volt_low;    // Low line voltage-low status
    logic dt_event;       // Dominant timeout level
    logic hi_oc;          // High line over-current level
    logic lo_oc;          // Low line over-current level
  } cpf_stat_s;
endpackage : cpf_pkg

/* src/cpf_flags.sv */
// Sticky fault flag register with enables and one interrupt line.
// Assumes detector inputs are asynchronous and held at least two cycles.
//
// Overview of operation
// - Writing one clears that flag only
// - Writing zero leaves flags unchanged
// - Enabled set flag holds interrupt pending
// - Bit 7 sets on high-line over-volt change
// - Bit 6 sets on high-line under-volt change
// - Flag register at offset 7, always accessible
// - Voltage flags gated by enable bit 4
// - Timeout flag gated by enable bit 3
// - Over-current flags gated by enable bit 0
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module cpf_flags
  import cpf_pkg::*;
(
  input  wire logic              CLK_I,        // 25 MHz clock
  input  wire logic              SYS_RST_I,    // Async reset, high
  input  wire logic [CPF_AW-1:0] ADDR_I,       // Register address
  input  wire logic [7:0]        WDATA_I,      // Write data
  input  wire logic              WR_I,         // Write strobe
  input  wire logic              RD_I,         // Read strobe
  input  wire cpf_stat_s         STAT_I,       // Detector levels
  output logic      [7:0]        RDATA_O,      // Read data, next cycle
  output logic                   IRQ_O         // Error interrupt, level
);

  cpf_stat_s   sync1;          // First synchroniser stage
  cpf_stat_s   sync2;          // Second synchroniser stage
  cpf_stat_s   prev;           // Last seen synced levels
  logic        primed;         // Prev holds a valid sample
  logic [7:0]  flags;          // Sticky flags
  logic [7:0]  enable;         // Enable register
  logic [7:0]  events;         // Set requests this cycle
  logic [7:0]  clr;            // Clear requests this cycle
  logic [7:0]  next_flags;     // Next flag value
  logic        next_irq;       // Next interrupt level
  logic [7:0]  status;         // Live status view

  // Two-flop synchroniser for detector inputs
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= STAT_I;
      sync2 <= sync1;
    end
  end

  // Previous sample for change detection
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      prev   <= '0;
      primed <= 1'b0;
    end else begin
      prev   <= sync2;
      primed <= 1'b1;
    end
  end

  // Event decode per flag bit
  always_comb begin
    events = 8'h00;
    if (primed) begin
      // Either-direction changes on the voltage status
      events[CPF_BIT_HVH] = sync2.hi_volt_high ^ prev.hi_volt_high;
      events[CPF_BIT_HVL] = sync2.hi_volt_low ^ prev.hi_volt_low;
      events[CPF_BIT_LVH] = sync2.lo_volt_high ^ prev.lo_volt_high;
      events[CPF_BIT_LVL] = sync2.lo_volt_low ^ prev.lo_volt_low;
      // Rising edges of fault levels
      events[CPF_BIT_DT]  = sync2.dt_event & ~prev.dt_event;
      events[CPF_BIT_HOC] = sync2.hi_oc & ~prev.hi_oc;
      events[CPF_BIT_LOC] = sync2.lo_oc & ~prev.lo_oc;
    end
  end

  // Write-one-to-clear decode on the flag address
  always_comb begin
    clr = 8'h00;
    if (WR_I && (ADDR_I == CPF_ADDR_FLAGS)) begin
      clr = WDATA_I;
    end
  end

  // Set wins over clear; bit 2 held at zero
  always_comb begin
    next_flags = ((flags & ~clr) | events) & CPF_FLAGS_MASK;
  end

  // Flag register
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      flags <= CPF_FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // Enable register
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      enable <= CPF_ENABLE_RST;
    end else if (WR_I && (ADDR_I == CPF_ADDR_ENABLE)) begin
      enable <= WDATA_I & CPF_ENABLE_MASK;
    end
  end

  // Interrupt gating by group enables, from present flags
  always_comb begin
    next_irq = 1'b0;
    if (enable[CPF_EN_VF] &&
        |flags[CPF_BIT_HVH:CPF_BIT_LVL]) begin
      next_irq = 1'b1;
    end
    if (enable[CPF_EN_DT] && flags[CPF_BIT_DT]) begin
      next_irq = 1'b1;
    end
    if (enable[CPF_EN_OC] &&
        (flags[CPF_BIT_HOC] || flags[CPF_BIT_LOC])) begin
      next_irq = 1'b1;
    end
  end

  // Registered interrupt output
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= next_irq;
    end
  end

  // Live status view
  always_comb begin
    status = {sync2.hi_volt_high, sync2.hi_volt_low, sync2.lo_volt_high,
              sync2.lo_volt_low, sync2.dt_event, 1'b0, sync2.hi_oc,
              sync2.lo_oc};
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        CPF_ADDR_FLAGS:  RDATA_O <= flags;
        CPF_ADDR_ENABLE: RDATA_O <= enable;
        CPF_ADDR_STATUS: RDATA_O <= status;
        default:         RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  // Assertions
  property p_w1c_clear;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (WR_I && ADDR_I == CPF_ADDR_FLAGS && events == 8'h00)
      |=> ((flags & $past(WDATA_I)) == 8'h00);
  endproperty
  a_w1c_clear: assert property (p_w1c_clear)
    else $error("flag not cleared by one write");

  property p_zero_keeps;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (WR_I && ADDR_I == CPF_ADDR_FLAGS)
      |=> ((flags & ~$past(WDATA_I)) == ($past(flags) & ~$past(WDATA_I)))
          || $past(events != 8'h00);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("zero write disturbed a flag");

  property p_irq_follows;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      ((|(flags[7:4]) && enable[CPF_EN_VF]) ||
       (flags[CPF_BIT_DT] && enable[CPF_EN_DT])) |=> IRQ_O;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt missing for enabled flag");

  property p_hvh_set;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (primed && sync2.hi_volt_high != prev.hi_volt_high)
      |=> flags[CPF_BIT_HVH];
  endproperty
  a_hvh_set: assert property (p_hvh_set)
    else $error("bit 7 not set on status change");

  property p_hvl_set;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      $changed(sync2.hi_volt_low) && $past(primed) ##1 1'b1
      |-> flags[CPF_BIT_HVL];
  endproperty
  a_hvl_set: assert property (p_hvl_set)
    else $error("bit 6 not set on status change");

  property p_read_flags;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (RD_I && ADDR_I == CPF_ADDR_FLAGS) |=> (RDATA_O == $past(flags));
  endproperty
  a_read_flags: assert property (p_read_flags)
    else $error("flag read data wrong");

  property p_bit2_zero;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (RD_I && ADDR_I == CPF_ADDR_FLAGS) |=> !RDATA_O[2];
  endproperty
  a_bit2_zero: assert property (p_bit2_zero)
    else $error("bit 2 read as one");

  property p_vf_gate;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (!enable[CPF_EN_VF] && !enable[CPF_EN_DT] && !enable[CPF_EN_OC])
      |=> !IRQ_O;
  endproperty
  a_vf_gate: assert property (p_vf_gate)
    else $error("interrupt with all enables off");

  property p_dt_gate;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (flags == 8'h08 && !enable[CPF_EN_DT]) |=> !IRQ_O;
  endproperty
  a_dt_gate: assert property (p_dt_gate)
    else $error("timeout interrupt while disabled");

  property p_oc_gate;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      ((flags & 8'hFC) == 8'h00 && !enable[CPF_EN_OC]) |=> !IRQ_O;
  endproperty
  a_oc_gate: assert property (p_oc_gate)
    else $error("over-current interrupt while disabled");

  // Without a flag write no set flag may drop
  property p_flag_sticky;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      !(WR_I && ADDR_I == CPF_ADDR_FLAGS)
      |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag lost without a one write");

  // Over-current flags with their enable raise the line
  property p_irq_oc;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (enable[CPF_EN_OC] && (flags[CPF_BIT_HOC] || flags[CPF_BIT_LOC]))
      |=> IRQ_O;
  endproperty
  a_irq_oc: assert property (p_irq_oc)
    else $error("interrupt missing for over-current flag");

  // No pending flag means no interrupt
  property p_irq_none;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (flags == 8'h00)
      |=> !IRQ_O;
  endproperty
  a_irq_none: assert property (p_irq_none)
    else $error("interrupt without a pending flag");

  // Voltage flags alone stay silent with their enable off
  property p_vf_only_gate;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (!enable[CPF_EN_VF] && (flags & 8'h0F) == 8'h00)
      |=> !IRQ_O;
  endproperty
  a_vf_only_gate: assert property (p_vf_only_gate)
    else $error("voltage interrupt while disabled");

  // Low line over-volt change sets bit 5
  property p_lvh_set;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (primed && sync2.lo_volt_high != prev.lo_volt_high)
      |=> flags[CPF_BIT_LVH];
  endproperty
  a_lvh_set: assert property (p_lvh_set)
    else $error("bit 5 not set on status change");

  // Low line under-volt change sets bit 4
  property p_lvl_set;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (primed && sync2.lo_volt_low != prev.lo_volt_low)
      |=> flags[CPF_BIT_LVL];
  endproperty
  a_lvl_set: assert property (p_lvl_set)
    else $error("bit 4 not set on status change");

  // Timeout rising edge sets bit 3
  property p_dt_set;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (primed && sync2.dt_event && !prev.dt_event)
      |=> flags[CPF_BIT_DT];
  endproperty
  a_dt_set: assert property (p_dt_set)
    else $error("bit 3 not set on timeout");

  // High line over-current rising edge sets bit 1
  property p_hoc_set;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (primed && sync2.hi_oc && !prev.hi_oc)
      |=> flags[CPF_BIT_HOC];
  endproperty
  a_hoc_set: assert property (p_hoc_set)
    else $error("bit 1 not set on over-current");

  // Low line over-current rising edge sets bit 0
  property p_loc_set;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (primed && sync2.lo_oc && !prev.lo_oc)
      |=> flags[CPF_BIT_LOC];
  endproperty
  a_loc_set: assert property (p_loc_set)
    else $error("bit 0 not set on over-current");

endmodule : cpf_flags
`default_nettype wire

/* bench/tb.sv */
// Testbench for the fault flag register: bus, flags and interrupt.
// Assumes cpf_pkg and cpf_flags are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cpf_pkg::*;
  logic              clk_i;      // Bench clock
  logic              sys_rst_i;  // Reset, high
  logic [CPF_AW-1:0] addr_i;     // Register address
  logic [7:0]        wdata_i;    // Write data
  logic              wr_i;       // Write strobe
  logic              rd_i;       // Read strobe
  cpf_stat_s         stat_i;     // Detector levels
  logic [7:0]        rdata_o;    // Read data
  logic              irq_o;      // Interrupt
  int                miscompares = 0;
  int                n_checks = 0;

  cpf_flags i_dut (.CLK_I(clk_i), .SYS_RST_I(sys_rst_i), .ADDR_I(addr_i),
    .WDATA_I(wdata_i), .WR_I(wr_i), .RD_I(rd_i), .STAT_I(stat_i),
    .RDATA_O(rdata_o), .IRQ_O(irq_o));

  // Free running 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Counted compare, reports at once
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One-cycle write
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // One-cycle read, data judged in the following cycle
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    check(rdata_o, exp);
  endtask : rd

  // Apply detector levels, then let sync and irq settle
  task put_stat(input logic [6:0] s);
    @(posedge clk_i);
    stat_i <= s;
    repeat (6) @(posedge clk_i);
  endtask : put_stat

  // Reset values, mapping, refused accesses
  task t_reset;
    rd(CPF_ADDR_FLAGS, 8'h00);
    rd(CPF_ADDR_ENABLE, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h00);
    rd(CPF_ADDR_ENABLE, 8'h00);
    wr(CPF_ADDR_STATUS, 8'hFF);
    rd(CPF_ADDR_STATUS, 8'h00);
    wr(CPF_ADDR_ENABLE, 8'hFF);
    rd(CPF_ADDR_ENABLE, CPF_ENABLE_MASK);
    wr(CPF_ADDR_ENABLE, 8'h00);
  endtask : t_reset

  // Each detector: rise, clear, fall, clear
  task t_events;
    int f;
    for (int k = 0; k < 7; k++) begin
      f = (k >= 2) ? k + 1 : k;
      put_stat(7'h01 << k);
      rd(CPF_ADDR_FLAGS, 8'h01 << f);
      rd(CPF_ADDR_STATUS, 8'h01 << f);
      wr(CPF_ADDR_FLAGS, 8'h01 << f);
      rd(CPF_ADDR_FLAGS, 8'h00);
      put_stat(7'h00);
      rd(CPF_ADDR_FLAGS, (k >= 3) ? (8'h01 << f) : 8'h00);
      rd(CPF_ADDR_STATUS, 8'h00);
      wr(CPF_ADDR_FLAGS, 8'hFF);
    end
  endtask : t_events

  // Zero writes keep flags, one writes clear only their bit
  task t_clear;
    put_stat(7'h41);
    wr(CPF_ADDR_FLAGS, 8'h00);
    rd(CPF_ADDR_FLAGS, 8'h81);
    wr(CPF_ADDR_FLAGS, 8'h80);
    rd(CPF_ADDR_FLAGS, 8'h01);
    wr(CPF_ADDR_FLAGS, 8'h01);
    rd(CPF_ADDR_FLAGS, 8'h00);
    put_stat(7'h00);
    wr(CPF_ADDR_FLAGS, 8'hFF);
  endtask : t_clear

  // Interrupt gating per enable bit
  task t_irq(input logic [7:0] en, input logic [6:0] s, input logic [7:0] fl);
    put_stat(s);
    @(negedge clk_i);
    check({7'h00, irq_o}, 8'h00);
    wr(CPF_ADDR_ENABLE, CPF_ENABLE_MASK & ~en);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({7'h00, irq_o}, 8'h00);
    wr(CPF_ADDR_ENABLE, en);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({7'h00, irq_o}, 8'h01);
    wr(CPF_ADDR_FLAGS, fl);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({7'h00, irq_o}, 8'h00);
    wr(CPF_ADDR_ENABLE, 8'h00);
    put_stat(7'h00);
    wr(CPF_ADDR_FLAGS, 8'hFF);
  endtask : t_irq

  // Reset in mid-run clears set flags, enables and interrupt
  task t_midreset;
    put_stat(7'h40);
    put_stat(7'h00);
    wr(CPF_ADDR_ENABLE, 8'hFF);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({7'h00, irq_o}, 8'h01);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    check({7'h00, irq_o}, 8'h00);
    rd(CPF_ADDR_FLAGS, 8'h00);
    rd(CPF_ADDR_ENABLE, 8'h00);
  endtask : t_midreset

  // Verdict and end of run
  task results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    addr_i    = '0;
    wdata_i   = 8'h00;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    stat_i    = '0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset;
    t_events;
    t_clear;
    t_irq(8'h10, 7'h40, 8'h80);
    t_irq(8'h10, 7'h08, 8'h10);
    t_irq(8'h08, 7'h04, 8'h08);
    t_irq(8'h01, 7'h02, 8'h02);
    t_irq(8'h01, 7'h01, 8'h01);
    t_midreset;
    results;
  end

  // Hang guard, far beyond the expected run
  initial begin
    #(5000 * 40);
    miscompares++;
    results;
  end
endmodule : tb
`default_nettype wire
